/* File: cms_defines.vh */
// Constants for the system clock generator
`ifndef CMS_DEFINES_VH
`define CMS_DEFINES_VH

// Clock mode select encodings
`define CMS_MODE_MID     2'h0
`define CMS_MODE_HIGH    2'h1
`define CMS_MODE_LOW     2'h2

// Half-period lengths in source rising edges, minus one
`define CMS_HALF_MID     3'h3
`define CMS_HALF_FAST    3'h0

// Oscillation control states
`define CMS_ST_RUN       2'h0
`define CMS_ST_WAIT      2'h1
`define CMS_ST_STOP      2'h2
`define CMS_ST_RECOVER   2'h3

// Counter presets applied at stop
`define CMS_PRE12_INIT   8'hff
`define CMS_T1_INIT      8'h01

// Count source divider used during stop recovery
`define CMS_SRC_DIV_LAST 4'hf

`endif

/* File: cms_system_clock_generator.v */
// System clock generator: oscillator control, speed divider, stop and wait
`timescale 1ns/1ps
`include "cms_defines.vh"

module cms_system_clock_generator (
	input  wire       CLK,
	input  wire       RESET,
	input  wire       MAIN_OSC_IN,
	input  wire       SUB_OSC_IN_I,
	output reg        SUB_OSC_IN_O,
	output reg        SUB_OSC_IN_OE,
	input  wire       SUB_OSC_OUT_I,
	output reg        SUB_OSC_OUT_O,
	output reg        SUB_OSC_OUT_OE,
	input  wire [1:0] SUB_PORT_DATA,
	input  wire [1:0] SUB_PORT_DIR,
	output reg  [1:0] SUB_PORT_PIN,
	input  wire [1:0] CLK_MODE_SEL,
	input  wire       MAIN_CLK_STOP,
	input  wire       SUB_OSC_ENABLE,
	input  wire       STAB_SET_BIT,
	input  wire       CNT_SRC_SEL,
	input  wire [7:0] PRE12_NOW,
	input  wire [7:0] T1_NOW,
	input  wire       STOP_INSTRUCTION,
	input  wire       WAIT_INSTRUCTION,
	input  wire       EXT_INT,
	input  wire       ANY_INT,
	output reg        PHI,
	output reg        MAIN_OSC_OUT,
	output reg        MAIN_OSC_RUN,
	output reg        SUB_OSC_RUN,
	output reg  [1:0] CLK_MODE_NOW,
	output reg        STOPPED,
	output reg        WAITING,
	output reg        T1_UNDERFLOW,
	output reg  [7:0] PRE12_COUNT,
	output reg  [7:0] T1_COUNT
);

	// Bit 0 main input, bit 1 sub input pin, bit 2 sub output pin
	wire [2:0] pin_w;
	reg  [2:0] s1_q;
	reg  [2:0] s2_q;
	reg  [2:0] s3_q;
	reg  [2:0] lvl_q;
	wire [2:0] agree_w;
	wire [2:0] rise_w;

	reg  [1:0] state_q;
	reg  [1:0] mode_q;
	reg  [2:0] hc_q;
	reg        stop_pend_q;
	reg        wait_pend_q;
	reg        src_q;
	reg  [3:0] dv_q;
	reg  [7:0] pre_rl_q;
	reg  [7:0] t1_rl_q;

	wire       main_tick_w;
	wire       sub_tick_w;
	wire       src_tick_w;
	wire [2:0] half_w;
	wire       freeze_w;
	wire       step_w;
	wire       toggle_w;
	wire [1:0] mode_d;
	wire       rec_tick_w;
	wire       cnt_tick_w;
	wire       main_run_d;
	wire       sub_run_d;

	assign pin_w   = {SUB_OSC_OUT_I, SUB_OSC_IN_I, MAIN_OSC_IN};
	assign agree_w = ~(s2_q ^ s3_q);
	assign rise_w  = agree_w & s3_q & ~lvl_q;

	// Three-stage synchronisers; the first stage feeds only the second
	always @(posedge CLK) begin
		if (RESET) begin
			s1_q  <= 3'h0;
			s2_q  <= 3'h0;
			s3_q  <= 3'h0;
			lvl_q <= 3'h0;
		end else begin
			s1_q  <= pin_w;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (lvl_q & ~agree_w) | (s3_q & agree_w);
		end
	end

	// Edges from a halted oscillator are ignored
	assign main_tick_w = rise_w[0] & MAIN_OSC_RUN;
	assign sub_tick_w  = rise_w[1] & SUB_OSC_RUN;

	assign src_tick_w = (mode_q == `CMS_MODE_LOW) ? sub_tick_w : main_tick_w;
	assign half_w = (mode_q == `CMS_MODE_MID) ? `CMS_HALF_MID : `CMS_HALF_FAST;

	// Unknown select code falls back to middle speed
	assign mode_d = (CLK_MODE_SEL == `CMS_MODE_HIGH) ? `CMS_MODE_HIGH :
			(CLK_MODE_SEL == `CMS_MODE_LOW) ? `CMS_MODE_LOW : `CMS_MODE_MID;

	// Frozen clock may still finish a low half, so it always parks high
	assign freeze_w = (state_q != `CMS_ST_RUN) | stop_pend_q | wait_pend_q;
	assign step_w   = src_tick_w & (~freeze_w | ~PHI);
	assign toggle_w = step_w & (hc_q == half_w);

	// divider toggles phi on source edges
	always @(posedge CLK) begin
		if (RESET) begin
			hc_q <= 3'h0;
			PHI  <= 1'b1;
		end else if (step_w) begin
			if (toggle_w) begin
				hc_q <= 3'h0;
				PHI  <= ~PHI;
			end else begin
				hc_q <= hc_q + 3'h1;
			end
		end
	end

	// mode taken only at rising phi
	always @(posedge CLK) begin
		if (RESET) begin
			mode_q       <= `CMS_MODE_MID;
			CLK_MODE_NOW <= `CMS_MODE_MID;
		end else begin
			if (toggle_w & ~PHI) begin
				mode_q <= mode_d;
			end
			CLK_MODE_NOW <= mode_q;
		end
	end

	// main stop honoured in low speed
	assign main_run_d = (state_q != `CMS_ST_STOP) &
			~((mode_q == `CMS_MODE_LOW) & MAIN_CLK_STOP);
	assign sub_run_d = SUB_OSC_ENABLE & (state_q != `CMS_ST_STOP);

	// Oscillator run enables, main on and sub off from reset
	always @(posedge CLK) begin
		if (RESET) begin
			MAIN_OSC_RUN <= 1'b1;
			SUB_OSC_RUN  <= 1'b0;
		end else begin
			MAIN_OSC_RUN <= main_run_d;
			SUB_OSC_RUN  <= sub_run_d;
		end
	end

	// sub pins act as port pins while the sub oscillator is halted
	always @(posedge CLK) begin
		if (RESET) begin
			SUB_OSC_IN_O   <= 1'b0;
			SUB_OSC_IN_OE  <= 1'b0;
			SUB_OSC_OUT_O  <= 1'b0;
			SUB_OSC_OUT_OE <= 1'b0;
			SUB_PORT_PIN   <= 2'h0;
			MAIN_OSC_OUT   <= 1'b1;
		end else begin
			SUB_OSC_IN_O   <= SUB_PORT_DATA[0];
			SUB_OSC_IN_OE  <= ~SUB_OSC_RUN & SUB_PORT_DIR[0];
			SUB_OSC_OUT_O  <= SUB_OSC_RUN ? ~lvl_q[1] : SUB_PORT_DATA[1];
			SUB_OSC_OUT_OE <= SUB_OSC_RUN | SUB_PORT_DIR[1];
			SUB_PORT_PIN   <= lvl_q[2:1];
			// Inverting amplifier output, parked high when halted
			MAIN_OSC_OUT   <= MAIN_OSC_RUN ? ~lvl_q[0] : 1'b1;
		end
	end

	assign rec_tick_w = src_q ? sub_tick_w : main_tick_w;
	assign cnt_tick_w = rec_tick_w & (dv_q == `CMS_SRC_DIV_LAST) &
			(state_q == `CMS_ST_RECOVER);

	// Oscillation control state machine and stop recovery counters
	always @(posedge CLK) begin
		if (RESET) begin
			state_q      <= `CMS_ST_RUN;
			stop_pend_q  <= 1'b0;
			wait_pend_q  <= 1'b0;
			src_q        <= 1'b0;
			dv_q         <= 4'h0;
			pre_rl_q     <= `CMS_PRE12_INIT;
			t1_rl_q      <= `CMS_T1_INIT;
			PRE12_COUNT  <= `CMS_PRE12_INIT;
			T1_COUNT     <= `CMS_T1_INIT;
			T1_UNDERFLOW <= 1'b0;
			STOPPED      <= 1'b0;
			WAITING      <= 1'b0;
		end else begin
			T1_UNDERFLOW <= 1'b0;
			STOPPED      <= (state_q == `CMS_ST_STOP) | (state_q == `CMS_ST_RECOVER);
			WAITING      <= (state_q == `CMS_ST_WAIT);
			case (state_q)
			`CMS_ST_RUN: begin
				// Requests wait until phi stands high
				if (STOP_INSTRUCTION) begin
					stop_pend_q <= 1'b1;
				end
				if (WAIT_INSTRUCTION) begin
					wait_pend_q <= 1'b1;
				end
				if (stop_pend_q & PHI) begin
					state_q     <= `CMS_ST_STOP;
					stop_pend_q <= 1'b0;
					wait_pend_q <= 1'b0;
					src_q       <= CNT_SRC_SEL;
					dv_q        <= 4'h0;
					if (~STAB_SET_BIT) begin
						pre_rl_q    <= `CMS_PRE12_INIT;
						t1_rl_q     <= `CMS_T1_INIT;
						PRE12_COUNT <= `CMS_PRE12_INIT;
						T1_COUNT    <= `CMS_T1_INIT;
					end else begin
						pre_rl_q    <= PRE12_NOW;
						t1_rl_q     <= T1_NOW;
						PRE12_COUNT <= PRE12_NOW;
						T1_COUNT    <= T1_NOW;
					end
				end else if (wait_pend_q & PHI) begin
					state_q     <= `CMS_ST_WAIT;
					wait_pend_q <= 1'b0;
				end
			end
			`CMS_ST_WAIT: begin
				if (ANY_INT) begin
					state_q <= `CMS_ST_RUN;
				end
			end
			`CMS_ST_STOP: begin
				if (EXT_INT) begin
					state_q <= `CMS_ST_RECOVER;
				end
			end
			`CMS_ST_RECOVER: begin
				if (rec_tick_w) begin
					dv_q <= dv_q + 4'h1;
				end
				if (cnt_tick_w) begin
					if (PRE12_COUNT == 8'h00) begin
						PRE12_COUNT <= pre_rl_q;
						if (T1_COUNT == 8'h00) begin
							T1_COUNT     <= t1_rl_q;
							T1_UNDERFLOW <= 1'b1;
							state_q      <= `CMS_ST_RUN;
						end else begin
							T1_COUNT <= T1_COUNT - 8'h01;
						end
					end else begin
						PRE12_COUNT <= PRE12_COUNT - 8'h01;
					end
				end
			end
			default: begin
				state_q <= `CMS_ST_RUN;
			end
			endcase
		end
	end

endmodule

/* File: scg_monitor.sv */
// Checker for the system clock generator ports
`timescale 1ns/1ps
module scg_monitor (
	input wire       CLK,
	input wire       RESET,
	input wire       MAIN_CLK_STOP,
	input wire       PHI,
	input wire       MAIN_OSC_RUN,
	input wire       SUB_OSC_RUN,
	input wire       SUB_OSC_IN_OE,
	input wire       SUB_OSC_OUT_OE,
	input wire [1:0] CLK_MODE_NOW,
	input wire       STOPPED,
	input wire       WAITING,
	input wire       T1_UNDERFLOW
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// Recovery pulse and low power request
	sequence s_uflow; T1_UNDERFLOW ##1 !T1_UNDERFLOW; endsequence
	sequence s_lowstop; MAIN_CLK_STOP && CLK_MODE_NOW == 2'h2 && !STOPPED; endsequence
	stop_freeze_a: assert property (STOPPED |-> PHI)
		else $error("clock low in stop");
	stop_halt_a: assert property ($rose(STOPPED) |-> !MAIN_OSC_RUN && !SUB_OSC_RUN)
		else $error("oscillator runs in stop");
	wait_hold_a: assert property (WAITING |-> PHI && MAIN_OSC_RUN)
		else $error("wait state wrong");
	uflow_pulse_a: assert property (T1_UNDERFLOW |-> s_uflow)
		else $error("underflow not one cycle");
	uflow_cause_a: assert property (T1_UNDERFLOW |-> $past(STOPPED))
		else $error("underflow outside recovery");
	sub_pins_a: assert property (SUB_OSC_RUN && $past(SUB_OSC_RUN) |-> !SUB_OSC_IN_OE && SUB_OSC_OUT_OE)
		else $error("sub pins still port");
	low_power_a: assert property (s_lowstop |-> ##[0:4] !MAIN_OSC_RUN)
		else $error("main not stopped");
	main_keep_a: assert property (!STOPPED && CLK_MODE_NOW != 2'h2 |-> ##[0:2] MAIN_OSC_RUN)
		else $error("main stopped outside low");
	// Short pulse on the clock would be a runt
	glitch_free_a: assert property ($changed(PHI) |=> $stable(PHI)[*3])
		else $error("runt on clock");
endmodule
bind cms_system_clock_generator scg_monitor i_mon (.CLK(CLK), .RESET(RESET),
	.MAIN_CLK_STOP(MAIN_CLK_STOP), .PHI(PHI), .MAIN_OSC_RUN(MAIN_OSC_RUN),
	.SUB_OSC_RUN(SUB_OSC_RUN), .SUB_OSC_IN_OE(SUB_OSC_IN_OE), .SUB_OSC_OUT_OE(SUB_OSC_OUT_OE),
	.CLK_MODE_NOW(CLK_MODE_NOW), .STOPPED(STOPPED), .WAITING(WAITING),
	.T1_UNDERFLOW(T1_UNDERFLOW));

/* File: scg_osc_model.sv */
// Resonator model for the main and sub oscillator pins
`timescale 1ns/1ps
module scg_osc_model (
	input  wire main_run,
	input  wire sub_run,
	output reg  main_clk,
	output reg  sub_clk
);
	// Halted resonators stand low
	initial begin
		main_clk = 1'b0;
		sub_clk  = 1'b0;
	end
	always #200 main_clk = main_run ? ~main_clk : 1'b0;
	always #700 sub_clk = sub_run ? ~sub_clk : 1'b0;
endmodule

/* File: tb_system_clock_generator.sv */
// Self-checking bench for the system clock generator
`timescale 1ns/1ps
`define CMP(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("Error %0t: got %h want %h", $time, g, e); end end
module tb_system_clock_generator;
	reg          clk = 0, reset = 1, stop_instruction = 0, wt = 0, ext = 0, anyi = 0, mstop = 0, suben = 0;
	reg          stab = 0, phd = 1, csrc = 0, lng = 0;
	reg   [1:0]  mode = 0, pdata = 0, pdir = 0;
	reg   [7:0]  pre = 0, t1 = 0;
	reg   [15:0] per = 0, cnt = 0;
	reg   [31:0] seed = 75;
	wire         main_clk, sub_clk, phi, mrun, srun, ioe, ooe, io, oo, stopped, waiting, uflow;
	wire  [7:0]  pc, tc;
	wire  [1:0]  mnow, spin;
	wire         mout;
	wire         sin = ioe ? io : sub_clk;
	wire         sout = ooe ? oo : ~sub_clk;
	int          err_total = 0, comparisons = 0, cyc = 0, i;
	logic [19:0] q[$], n;
	event        shot;
	always #25 clk = ~clk;
	cms_system_clock_generator i_dut (.CLK(clk), .RESET(reset), .MAIN_OSC_IN(main_clk),
		.SUB_OSC_IN_I(sin), .SUB_OSC_IN_O(io), .SUB_OSC_IN_OE(ioe), .SUB_OSC_OUT_I(sout),
		.SUB_OSC_OUT_O(oo), .SUB_OSC_OUT_OE(ooe), .SUB_PORT_DATA(pdata), .SUB_PORT_DIR(pdir),
		.SUB_PORT_PIN(spin), .CLK_MODE_SEL(mode), .MAIN_CLK_STOP(mstop), .SUB_OSC_ENABLE(suben),
		.STAB_SET_BIT(stab), .CNT_SRC_SEL(csrc), .PRE12_NOW(pre), .T1_NOW(t1),
		.STOP_INSTRUCTION(stop_instruction), .WAIT_INSTRUCTION(wt), .EXT_INT(ext), .ANY_INT(anyi),
		.PHI(phi), .MAIN_OSC_OUT(mout), .MAIN_OSC_RUN(mrun), .SUB_OSC_RUN(srun),
		.CLK_MODE_NOW(mnow), .STOPPED(stopped), .WAITING(waiting), .T1_UNDERFLOW(uflow),
		.PRE12_COUNT(pc), .T1_COUNT(tc));
	scg_osc_model i_osc (.main_run(mrun), .sub_run(srun), .main_clk(main_clk), .sub_clk(sub_clk));
	// Timeout and clock period meter
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test;
		end
		if (phi && !phd) begin
			per <= cnt;
			cnt <= 16'h1;
		end else cnt <= cnt + 16'h1;
		phd <= phi;
	end
	function [15:0] obs(input [3:0] s);
		case (s)
			0: obs = {mrun, srun, stopped, waiting};
			1: obs = per;
			2: obs = {pc, tc};
			3: obs = {ooe, ioe, oo, io};
			4: obs = uflow;
			5: obs = mnow;
			6: obs = spin;
			7: obs = mout;
			8: obs = lng;
			default: obs = 16'h0;
		endcase
	endfunction
	function [31:0] xs(input [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	// Oldest notes against what the outputs show; drains all notes of one step
	initial forever begin
		@shot;
		while (q.size() > 0) begin
			n = q.pop_front();
			`CMP(obs(n[19:16]), n[15:0])
		end
	end
	task note(input [3:0] s, input [15:0] v); q.push_back({s, v}); ->shot; endtask
	task tick(input int k); repeat (k) @(negedge clk); endtask
	// Third rise: period of settled mode
	task per_chk(input [15:0] e); repeat (3) @(posedge phi); tick(1); note(1, e); endtask
	// bench raises no timer interrupt before stop
	task stop_now; stop_instruction = 1; tick(1); stop_instruction = 0;
		for (i = 0; i < 100 && stopped !== 1'b1; i++) tick(1);
		tick(1); endtask
	task finish_test;
		$display("Mismatches %0d of %0d comparisons", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		tick(8); reset = 0; tick(1);
		note(0, 16'h8);
		per_chk(16'd64);
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed); {pdir, pdata} = seed[3:0]; tick(8);
			note(3, {12'h0, pdir[1], pdir[0], pdata[1], pdata[0]});
			note(6, {14'h0, pdir[1] ? pdata[1] : 1'b1, pdir[0] ? pdata[0] : 1'b0});
		end
		mode = 2'h1; per_chk(16'd16);
		note(5, 16'h1);
		pdir = 0; suben = 1; mode = 2'h2; per_chk(16'd56);
		note(5, 16'h2);
		mstop = 1; tick(10); note(0, 16'h4);
		note(7, 16'h1);
		mstop = 0; tick(10); note(0, 16'hc);
		mode = 2'h1; per_chk(16'd16);
		wt = 1; tick(1); wt = 0; tick(20); note(0, 16'hd);
		anyi = 1; tick(1); anyi = 0; per_chk(16'd16);
		seed = xs(seed); pre = {6'h0, seed[1:0]}; stab = 1; csrc = 1; stop_now;
		note(0, 16'h2);
		note(2, {pre, t1});
		ext = 1; tick(1); ext = 0;
		for (i = 0; i < 3000 && uflow !== 1'b1; i++) tick(1);
		note(4, 16'h1);
		// Sub source counts far slower than main; the length shows the source
		lng = i > 300 * (pre + 1);
		note(8, 16'h1);
		per_chk(16'd16);
		mode = 2'h3; per_chk(16'd64);
		note(5, 16'h0);
		stab = 0; csrc = 0; stop_now; note(2, 16'hff01);
		suben = 0; mode = 0; reset = 1; tick(8); reset = 0; tick(1);
		note(0, 16'h8);
		tick(1);
		finish_test;
	end
endmodule
